// *** logic/erb_ram.sv ***
// Embedded RAM block: shared word array, per-port access latches, optional
// output registers and the shift-register and FIFO arrangements.
// Assumes one clock mclk with synchronous reset; user logic steers the
// per-side enables to emulate separate clock rates and avoids write collisions.
`timescale 1ns/100ps
`default_nettype none
module erb_ram
  import erb_pkg::*;
#(
  parameter erb_mode_type MODE       = ERB_SDP,
  parameter int           A_W        = 16,
  parameter int           B_W        = 16,
  parameter bit           OUT_REG    = 1'b0,
  parameter int           SR_W       = 8,
  parameter int           SR_TAP_LEN = 16,
  parameter int           SR_TAPS    = 2,
  parameter int           FIFO_DEPTH = ERB_FIFO_DEPTH,
  parameter int           INIT_SEED  = 0,
  localparam int          TOTAL      = erb_total_bits(A_W),
  localparam int          A_AW       = $clog2(TOTAL / A_W),
  localparam int          B_AW       = $clog2(TOTAL / B_W)
)(
  input  wire logic                    mclk,          // Clock, 100 MHz.
  input  wire logic                    rst,           // Synchronous reset, active high.
  input  wire logic                    a_in_en,       // Port A input-side enable.
  input  wire logic                    a_out_en,      // Port A output-register enable.
  input  wire logic [A_AW-1:0]         a_addr,        // Port A address.
  input  wire logic [A_W-1:0]          a_wdata,       // Port A write data.
  input  wire logic                    a_we,          // Port A write enable.
  input  wire logic                    a_re,          // Port A read enable.
  output logic      [A_W-1:0]          a_rdata,       // Port A read data.
  input  wire logic                    b_in_en,       // Port B input-side enable.
  input  wire logic                    b_out_en,      // Port B output-register enable.
  input  wire logic [B_AW-1:0]         b_addr,        // Port B address.
  input  wire logic [B_W-1:0]          b_wdata,       // Port B write data.
  input  wire logic                    b_we,          // Port B write enable.
  input  wire logic                    b_re,          // Port B read enable.
  output logic      [B_W-1:0]          b_rdata,       // Port B read data.
  output logic                         tdp_collision, // Both ports wrote one word.
  output logic      [SR_W*SR_TAPS-1:0] sr_taps,       // Shift register taps.
  output logic                         fifo_wr_ready, // FIFO accepts a write.
  output logic                         fifo_rd_valid, // FIFO holds a word.
  output logic      [A_W-1:0]          fifo_rd_data,  // FIFO head word.
  output logic                         fifo_empty,    // FIFO empty.
  output logic                         fifo_full      // FIFO full.
);

  localparam int MIN_W = (A_W < B_W) ? A_W : B_W;
  localparam int WORDS = TOTAL / MIN_W;
  localparam int A_R   = A_W / MIN_W;
  localparam int B_R   = B_W / MIN_W;

  localparam bit IS_SDP   = (MODE == ERB_SDP);
  localparam bit IS_TDP   = (MODE == ERB_TDP);
  localparam bit IS_ROM   = (MODE == ERB_ROM);
  localparam bit IS_SHIFT = (MODE == ERB_SHIFT);
  localparam bit IS_FIFO  = (MODE == ERB_FIFO);
  localparam int MAX_W    = IS_TDP ? ERB_TDP_MAX_W : ERB_SDP_MAX_W;

  // Width checks for the chosen mode.
  if (!erb_width_ok(A_W, MAX_W) || !erb_width_ok(B_W, MAX_W)) begin : g_bad_shape
    $error("erb_ram port width is not a legal shape for this mode");
  end
  if (erb_parity_width(A_W) != erb_parity_width(B_W)) begin : g_bad_family
    $error("erb_ram ports mix the parity and plain width families");
  end
  if (IS_SHIFT && SR_W > A_W) begin : g_bad_sr
    $error("erb_ram shift word is wider than port A");
  end

  typedef logic [MIN_W-1:0] erb_word_type;

  erb_word_type   mem_reg [WORDS];
  erb_word_type   mem_next [WORDS];
  logic [A_W-1:0] a_lat_reg, a_lat_next, a_out_reg, a_out_next, a_rd_word;
  logic [B_W-1:0] b_lat_reg, b_lat_next, b_out_reg, b_out_next, b_rd_word;
  logic           coll_reg, coll_next;
  int             a_base;
  int             b_base;
  logic           a_wr_go;
  logic           b_wr_go;

  // Stand-in for the memory initialisation file: a fixed pattern per word.
  function automatic erb_word_type memory_init_file_word(input int idx);
    return MIN_W'(idx ^ INIT_SEED);
  endfunction : memory_init_file_word

  assign a_base  = int'(a_addr) * A_R;
  assign b_base  = int'(b_addr) * B_R;
  assign a_wr_go = a_in_en && a_we && (IS_SDP || IS_TDP);
  assign b_wr_go = b_in_en && b_we && IS_TDP;

  // Word array. Port B is applied after port A, so a collision keeps port B's
  // data here, but the user logic must not rely on that.
  always_comb begin
    mem_next = mem_reg;
    if (rst && IS_ROM) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_next[i] = memory_init_file_word(i);
      end
    end else begin
      if (a_wr_go) begin
        for (int k = 0; k < A_R; k++) begin
          mem_next[a_base + k] = a_wdata[k*MIN_W +: MIN_W];
        end
      end
      if (b_wr_go) begin
        for (int k = 0; k < B_R; k++) begin
          mem_next[b_base + k] = b_wdata[k*MIN_W +: MIN_W];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    mem_reg <= mem_next;
  end

  // Read words from the contents held before this edge's writes.
  always_comb begin
    a_rd_word = '0;
    b_rd_word = '0;
    for (int k = 0; k < A_R; k++) begin
      a_rd_word[k*MIN_W +: MIN_W] = mem_reg[a_base + k];
    end
    for (int k = 0; k < B_R; k++) begin
      b_rd_word[k*MIN_W +: MIN_W] = mem_reg[b_base + k];
    end
  end

  // Access latches: the address and enables are taken at the edge, which is
  // the input register; no reset term acts on the enables themselves.
  always_comb begin
    a_lat_next = a_lat_reg;
    b_lat_next = b_lat_reg;
    if (a_in_en) begin
      if (IS_TDP && a_we) begin
        a_lat_next = a_wdata;
      end else if ((IS_TDP || IS_ROM) && a_re) begin
        a_lat_next = a_rd_word;
      end
    end
    if (b_in_en) begin
      if (IS_TDP && b_we) begin
        b_lat_next = b_wdata;
      end else if ((IS_TDP || IS_SDP) && b_re) begin
        b_lat_next = b_rd_word;
      end
    end
    if (rst) begin
      a_lat_next = A_W'(ERB_OUT_RESET);
      b_lat_next = B_W'(ERB_OUT_RESET);
    end
  end

  always_ff @(posedge mclk) begin
    a_lat_reg <= a_lat_next;
    b_lat_reg <= b_lat_next;
  end

  // Optional output registers, each with its own enable.
  always_comb begin
    a_out_next = a_out_reg;
    b_out_next = b_out_reg;
    if (a_out_en) begin
      a_out_next = a_lat_reg;
    end
    if (b_out_en) begin
      b_out_next = b_lat_reg;
    end
    if (rst) begin
      a_out_next = A_W'(ERB_OUT_RESET);
      b_out_next = B_W'(ERB_OUT_RESET);
    end
  end

  always_ff @(posedge mclk) begin
    a_out_reg <= a_out_next;
    b_out_reg <= b_out_next;
  end

  assign a_rdata = OUT_REG ? a_out_reg : a_lat_reg;
  assign b_rdata = OUT_REG ? b_out_reg : b_lat_reg;

  // Flags a same-word write on both ports one cycle after it happened.
  always_comb begin
    coll_next = a_wr_go && b_wr_go &&
                (a_base < b_base + B_R) && (b_base < a_base + A_R);
    if (rst) begin
      coll_next = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    coll_reg <= coll_next;
  end

  assign tdp_collision = coll_reg;

  erb_shreg #(
    .W       (SR_W),
    .TAP_LEN (SR_TAP_LEN),
    .TAPS    (SR_TAPS)
  ) u_shreg (
    .mclk     (mclk),
    .rst      (rst),
    .shift_en (IS_SHIFT && a_in_en),
    .shift_in (a_wdata[SR_W-1:0]),
    .taps     (sr_taps)
  );

  erb_fifo #(
    .W     (A_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (IS_FIFO && a_we),
    .in_ready  (fifo_wr_ready),
    .in_data   (a_wdata),
    .out_valid (fifo_rd_valid),
    .out_ready (IS_FIFO && b_re),
    .out_data  (fifo_rd_data),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );

endmodule : erb_ram
`default_nettype wire

// *** logic/erb_pkg.sv ***
// Constants, mode enumeration and width checks shared by the embedded RAM block.
// Assumes a single-clock fabric around the block; no registers are reached by software.
//
// Behaviour
// - Simple dual-port: mixed widths allowed inside one family, never across families.
// - Simple dual-port has one write enable, one read enable; no clear on them.
// - Simple dual-port read output holds its data while read enable is low.
// - Simple dual-port read of the address being written returns the old data.
// - Simple dual-port runs with input/output enables besides read/write enables.
// - True dual-port: two reads, two writes or read plus write, any rates.
// - True dual-port runs with input/output enables besides per-port enables.
// - True dual-port widest shape is 256 by 16, or 18 with parity.
// - True dual-port mixed widths allowed inside one family, never across.
// - True dual-port write flows through to the same port's read output.
// - Shift register width times tap length times taps at most 4,608 bits.
// - Shift register width times taps at most 36 bits.
// - Shift register reads before writing each location, one step per cycle.
// - ROM is preloaded, address registered, output registered or not, single-port reads.
// - FIFO inputs synchronous, FIFO outputs combinational.
// - Write side takes data, address, write enable; read side the rest.
// - Each true dual-port side has its own enable for all its registers.
// - Data outputs are zero after reset, even with preloaded contents; fifo_rd_data is not cleared.
package erb_pkg;

  localparam int ERB_PLAIN_BITS  = 4096;
  localparam int ERB_PARITY_BITS = 4608;
  localparam int ERB_PARITY_UNIT = 9;
  localparam int ERB_SDP_MAX_W   = 36;
  localparam int ERB_TDP_MAX_W   = 18;
  localparam int ERB_SR_MAX_BITS = 4608;
  localparam int ERB_SR_MAX_W    = 36;
  localparam int ERB_FIFO_DEPTH  = 4;
  localparam logic [35:0] ERB_OUT_RESET = 36'h0_0000_0000;

  typedef enum logic [2:0] {
    ERB_SDP,
    ERB_TDP,
    ERB_SHIFT,
    ERB_ROM,
    ERB_FIFO
  } erb_mode_type;

  function automatic bit erb_parity_width(input int w);
    return (w % ERB_PARITY_UNIT) == 0;
  endfunction : erb_parity_width

  // Width is one of the documented port shapes and not above max_w.
  function automatic bit erb_width_ok(input int w, input int max_w);
    bit shape;
    shape = (w == 1) || (w == 2) || (w == 4) || (w == 8) || (w == 16) || (w == 32) ||
            (w == 9) || (w == 18) || (w == 36);
    return shape && (w <= max_w);
  endfunction : erb_width_ok

  function automatic int erb_total_bits(input int w);
    return erb_parity_width(w) ? ERB_PARITY_BITS : ERB_PLAIN_BITS;
  endfunction : erb_total_bits

endpackage : erb_pkg

// *** logic/erb_fifo.sv ***
// Small show-ahead FIFO used in FIFO mode of the embedded RAM block.
// Assumes one clock and synchronous reset; the drain side may stall freely.
`timescale 1ns/100ps
`default_nettype none
module erb_fifo
  import erb_pkg::*;
#(
  parameter int W     = 16,
  parameter int DEPTH = ERB_FIFO_DEPTH
)(
  input  wire logic         mclk,      // Clock.
  input  wire logic         rst,       // Synchronous reset, active high.
  input  wire logic         in_valid,  // Write request.
  output logic              in_ready,  // Room for a word.
  input  wire logic [W-1:0] in_data,   // Write data.
  output logic              out_valid, // A word is available.
  input  wire logic         out_ready, // Read request.
  output logic [W-1:0]      out_data,  // Head word, combinational.
  output logic              empty,     // No words held.
  output logic              full       // All words held.
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2) begin : g_bad_depth
    $error("erb_fifo needs a depth of at least two");
  end

  logic [W-1:0]  mem_reg [DEPTH];
  logic [W-1:0]  mem_next [DEPTH];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic          do_wr, do_rd;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign empty     = (count_reg == '0);
  assign full      = (count_reg == CW'(DEPTH));
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_reg[rd_ptr_reg];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_comb begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (do_wr) begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next          = bump(wr_ptr_reg);
    end
    if (do_rd) begin
      rd_ptr_next = bump(rd_ptr_reg);
    end
    if (do_wr && !do_rd) begin
      count_next = count_reg + 1'b1;
    end else if (do_rd && !do_wr) begin
      count_next = count_reg - 1'b1;
    end
    if (rst) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next  = '0;
    end
  end

  always_ff @(posedge mclk) begin
    mem_reg    <= mem_next;
    wr_ptr_reg <= wr_ptr_next;
    rd_ptr_reg <= rd_ptr_next;
    count_reg  <= count_next;
  end

endmodule : erb_fifo
`default_nettype wire

// *** logic/erb_shreg.sv ***
// Tapped shift register held in a circular word store of the embedded RAM block.
// Assumes one clock and synchronous reset; stored words are not cleared by reset.
`timescale 1ns/100ps
`default_nettype none
module erb_shreg
  import erb_pkg::*;
#(
  parameter int W       = 8,
  parameter int TAP_LEN = 16,
  parameter int TAPS    = 2
)(
  input  wire logic                mclk,     // Clock.
  input  wire logic                rst,      // Synchronous reset, active high.
  input  wire logic                shift_en, // Advance one position.
  input  wire logic [W-1:0]        shift_in, // New word.
  output logic      [W*TAPS-1:0]   taps      // Tap k in slice k, registered.
);

  localparam int L  = TAP_LEN * TAPS;
  localparam int PW = (L > 1) ? $clog2(L) : 1;

  if (W * TAP_LEN * TAPS > ERB_SR_MAX_BITS) begin : g_bad_bits
    $error("erb_shreg holds too many bits; cascade blocks instead");
  end
  if (W * TAPS > ERB_SR_MAX_W || TAP_LEN < 1 || W < 1 || TAPS < 1) begin : g_bad_width
    $error("erb_shreg tap word is too wide");
  end

  logic [W-1:0]      mem_reg [L];
  logic [W-1:0]      mem_next [L];
  logic [PW-1:0]     ptr_reg, ptr_next;
  logic [W*TAPS-1:0] taps_reg, taps_next;

  assign taps = taps_reg;

  // Taps are read from the old contents before the new word lands, which gives
  // the read-then-write order of a two-edge store within one rising edge.
  always_comb begin
    mem_next  = mem_reg;
    ptr_next  = ptr_reg;
    taps_next = taps_reg;
    if (shift_en) begin
      for (int k = 0; k < TAPS; k++) begin
        taps_next[k*W +: W] = mem_reg[(int'(ptr_reg) + L - (k + 1) * TAP_LEN) % L];
      end
      mem_next[ptr_reg] = shift_in;
      ptr_next = (ptr_reg == PW'(L - 1)) ? '0 : ptr_reg + 1'b1;
    end
    if (rst) begin
      ptr_next  = '0;
      taps_next = '0;
    end
  end

  always_ff @(posedge mclk) begin
    mem_reg  <= mem_next;
    ptr_reg  <= ptr_next;
    taps_reg <= taps_next;
  end

endmodule : erb_shreg
`default_nettype wire

// *** tb/erb_ram_assertions.sv ***
// Concurrent checks on the ports of the embedded RAM block, bound to every instance.
// Assumes the single clock mclk and synchronous active-high reset of the block.
`timescale 1ns/100ps
`default_nettype none
module erb_ram_assertions
  import erb_pkg::*;
#(
  parameter erb_mode_type MODE    = ERB_SDP,
  parameter int           A_W     = 16,
  parameter int           B_W     = 16,
  parameter int           SR_W    = 8,
  parameter int           SR_TAPS = 2,
  parameter int           A_AW    = 8,
  parameter int           B_AW    = 8
)(
  input wire logic                    mclk,          // Clock.
  input wire logic                    rst,           // Reset.
  input wire logic                    a_in_en,       // A input enable.
  input wire logic                    a_out_en,      // A output enable.
  input wire logic [A_AW-1:0]         a_addr,        // A address.
  input wire logic [A_W-1:0]          a_wdata,       // A write data.
  input wire logic                    a_we,          // A write enable.
  input wire logic                    a_re,          // A read enable.
  input wire logic [A_W-1:0]          a_rdata,       // A read data.
  input wire logic                    b_in_en,       // B input enable.
  input wire logic                    b_out_en,      // B output enable.
  input wire logic [B_AW-1:0]         b_addr,        // B address.
  input wire logic [B_W-1:0]          b_wdata,       // B write data.
  input wire logic                    b_we,          // B write enable.
  input wire logic                    b_re,          // B read enable.
  input wire logic [B_W-1:0]          b_rdata,       // B read data.
  input wire logic                    tdp_collision, // Collision flag.
  input wire logic [SR_W*SR_TAPS-1:0] sr_taps,       // Shift taps.
  input wire logic                    fifo_wr_ready, // FIFO room.
  input wire logic                    fifo_rd_valid, // FIFO word held.
  input wire logic [A_W-1:0]          fifo_rd_data,  // FIFO head.
  input wire logic                    fifo_empty,    // FIFO empty.
  input wire logic                    fifo_full      // FIFO full.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  localparam bit SDP  = (MODE == ERB_SDP);
  localparam bit FIFO = (MODE == ERB_FIFO);
  sequence s_push_empty; FIFO && fifo_empty && a_we && fifo_wr_ready; endsequence
  sequence s_head_new; fifo_rd_valid && (fifo_rd_data == $past(a_wdata)); endsequence

  a_rd_hold: assert property (SDP && !(b_in_en && b_re) |=> $stable(b_rdata))
    else $error("read data changed without a read");
  a_out_cleared: assert property ($fell(rst) |-> a_rdata == '0 && b_rdata == '0)
    else $error("read data not zero after reset");
  a_port_a_mute: assert property (SDP |-> a_rdata == '0)
    else $error("write side produced read data");
  a_fifo_flags: assert property (FIFO |-> fifo_wr_ready == !fifo_full && fifo_rd_valid == !fifo_empty)
    else $error("fifo handshake disagrees with flags");
  a_full_holds: assert property (FIFO && fifo_full && !b_re |=> fifo_full)
    else $error("full dropped without a read");
  a_empty_holds: assert property (FIFO && fifo_empty && !a_we |=> fifo_empty)
    else $error("empty dropped without a write");
  a_first_push: assert property (s_push_empty |=> s_head_new)
    else $error("pushed word not shown at head");
  a_head_steady: assert property (FIFO && fifo_rd_valid && !b_re |=> $stable(fifo_rd_data))
    else $error("head word changed without a read");
endmodule : erb_ram_assertions
bind erb_ram erb_ram_assertions #(
  .MODE(MODE), .A_W(A_W), .B_W(B_W), .SR_W(SR_W), .SR_TAPS(SR_TAPS), .A_AW(A_AW), .B_AW(B_AW)
) u_erb_chk (
  .mclk(mclk), .rst(rst), .a_in_en(a_in_en), .a_out_en(a_out_en), .a_addr(a_addr),
  .a_wdata(a_wdata), .a_we(a_we), .a_re(a_re), .a_rdata(a_rdata), .b_in_en(b_in_en),
  .b_out_en(b_out_en), .b_addr(b_addr), .b_wdata(b_wdata), .b_we(b_we), .b_re(b_re),
  .b_rdata(b_rdata), .tdp_collision(tdp_collision), .sr_taps(sr_taps),
  .fifo_wr_ready(fifo_wr_ready), .fifo_rd_valid(fifo_rd_valid), .fifo_rd_data(fifo_rd_data),
  .fifo_empty(fifo_empty), .fifo_full(fifo_full)
);
`default_nettype wire

// *** tb/erb_user_sink.sv ***
// Fabric-side consumer model that drains the FIFO of the embedded RAM block.
// Assumes the block's clock and reset; stall makes it slow.
`timescale 1ns/100ps
`default_nettype none
module erb_user_sink
  import erb_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic         mclk,     // Clock.
  input  wire logic         rst,      // Synchronous reset.
  input  wire logic         rd_valid, // FIFO holds a word.
  input  wire logic [W-1:0] rd_data,  // FIFO head word.
  input  wire logic         stall,    // Hold off reading.
  output logic              rd_ready, // Read request.
  output logic [7:0]        got_cnt,  // Words taken.
  output logic [W-1:0]      got_last  // Last word taken.
);
  // Never asks while empty, so a read never meets a write on an empty FIFO.
  assign rd_ready = rd_valid && !stall;
  always_ff @(posedge mclk) begin
    if (rst) begin
      got_cnt  <= 8'h00;
      got_last <= '0;
    end else if (rd_ready) begin
      got_cnt  <= got_cnt + 8'h01;
      got_last <= rd_data;
    end
  end
endmodule : erb_user_sink
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench: mixed-width simple and true dual-port blocks and a FIFO-mode block.
// Assumes the checker is bound to every block instance.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import erb_pkg::*;
  logic        mclk, rst = 1'b1, zero = 1'b0, stall = 1'b0;
  logic        a_in_en = 1'b0, a_we = 1'b0, a_re = 1'b0, b_in_en = 1'b0, b_re = 1'b0;
  logic        b_we = 1'b0;
  logic        f_we = 1'b0, f_rdy, f_valid, f_empty, f_full, f_ready;
  logic [7:0]  a_addr = 8'h00, b_rdata, got_cnt, b_wdata = 8'h00, t_brdata;
  logic [15:0] t_ardata;
  logic [8:0]  b_addr = 9'h000;
  logic [15:0] a_wdata = 16'h0000, f_wdata = 16'h0000, a_rdata, f_rdata, got_last;
  int          error_cnt = 0, tests_run = 0;

  erb_ram #(.MODE(ERB_SDP), .A_W(16), .B_W(8)) DUT (
    .mclk(mclk), .rst(rst), .a_in_en(a_in_en), .a_out_en(zero), .a_addr(a_addr),
    .a_wdata(a_wdata), .a_we(a_we), .a_re(a_re), .a_rdata(a_rdata), .b_in_en(b_in_en),
    .b_out_en(zero), .b_addr(b_addr), .b_wdata(b_wdata), .b_we(b_we), .b_re(b_re),
    .b_rdata(b_rdata), .tdp_collision(), .sr_taps(), .fifo_wr_ready(), .fifo_rd_valid(),
    .fifo_rd_data(), .fifo_empty(), .fifo_full());
  erb_ram #(.MODE(ERB_FIFO), .A_W(16), .B_W(8)) dut_fifo (
    .mclk(mclk), .rst(rst), .a_in_en(a_in_en), .a_out_en(zero), .a_addr(a_addr),
    .a_wdata(f_wdata), .a_we(f_we), .a_re(a_re), .a_rdata(), .b_in_en(b_in_en),
    .b_out_en(zero), .b_addr(b_addr), .b_wdata(b_wdata), .b_we(b_we), .b_re(f_rdy),
    .b_rdata(), .tdp_collision(), .sr_taps(), .fifo_wr_ready(f_ready), .fifo_rd_valid(f_valid),
    .fifo_rd_data(f_rdata), .fifo_empty(f_empty), .fifo_full(f_full));
  erb_ram #(.MODE(ERB_TDP), .A_W(16), .B_W(8)) dut_tdp (
    .mclk(mclk), .rst(rst), .a_in_en(a_in_en), .a_out_en(a_in_en), .a_addr(a_addr),
    .a_wdata(a_wdata), .a_we(a_we), .a_re(a_re), .a_rdata(t_ardata), .b_in_en(b_in_en),
    .b_out_en(b_in_en), .b_addr(b_addr), .b_wdata(b_wdata), .b_we(b_we), .b_re(b_re),
    .b_rdata(t_brdata), .tdp_collision(), .sr_taps(), .fifo_wr_ready(), .fifo_rd_valid(),
    .fifo_rd_data(), .fifo_empty(), .fifo_full());
  erb_user_sink #(.W(16)) u_sink (
    .mclk(mclk), .rst(rst), .rd_valid(f_valid), .rd_data(f_rdata), .stall(stall),
    .rd_ready(f_rdy), .got_cnt(got_cnt), .got_last(got_last));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] addr, input logic [15:0] d);
    @(posedge mclk);
    a_in_en <= 1'b1;
    a_we    <= 1'b1;
    a_addr  <= addr;
    a_wdata <= d;
    @(posedge mclk);
    a_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [8:0] addr, output logic [7:0] q);
    @(posedge mclk);
    b_in_en <= 1'b1;
    b_re    <= 1'b1;
    b_addr  <= addr;
    @(posedge mclk);
    b_re <= 1'b0;
    @(negedge mclk);
    q = b_rdata;
  endtask : rd

  task automatic wait_empty;
    int n;
    n = 0;
    while (f_empty !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (f_empty !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, f_empty, 1'b1);
      end_of_test;
    end
  endtask : wait_empty

  task automatic t_reset;
    chk(b_rdata, 16'h0000);
    chk(a_rdata, 16'h0000);
    chk(t_ardata, 16'h0000);
    chk(f_empty, 16'h0001);
  endtask : t_reset

  // Wide word 5 splits into narrow words 10 and 11, low half first.
  task automatic t_mixed;
    logic [7:0] q;
    wr(8'h05, 16'hABCD);
    rd(9'h00A, q);
    chk(q, 16'h00CD);
    rd(9'h00B, q);
    chk(q, 16'h00AB);
    chk(t_ardata, 16'hABCD);
  endtask : t_mixed

  task automatic t_hold;
    @(posedge mclk);
    a_re    <= 1'b1;
    b_addr  <= 9'h00A;
    b_we    <= 1'b1;  // Port B writes in the true dual-port block while port A reads.
    b_wdata <= 8'hEE;
    repeat (3) @(posedge mclk);
    a_re <= 1'b0;
    b_we <= 1'b0;
    @(negedge mclk);
    chk(b_rdata, 16'h00AB);
    chk(a_rdata, 16'h0000);
    chk(t_ardata, 16'hABEE);
    chk(t_brdata, 16'h00EE);
  endtask : t_hold

  task automatic t_rdw;
    logic [7:0] q;
    @(posedge mclk);
    a_we    <= 1'b1;
    a_addr  <= 8'h05;
    a_wdata <= 16'h1234;
    b_re    <= 1'b1;
    b_addr  <= 9'h00A;
    @(posedge mclk);
    a_we <= 1'b0;
    b_re <= 1'b0;
    @(negedge mclk);
    chk(b_rdata, 16'h00CD);
    chk(t_brdata, 16'h00EE);
    chk(t_ardata, 16'h1234);
    @(posedge mclk);
    a_in_en <= 1'b0;
    a_we    <= 1'b1;
    a_wdata <= 16'hFFFF;
    @(posedge mclk);
    a_we    <= 1'b0;
    a_in_en <= 1'b1;
    rd(9'h00A, q);
    chk(q, 16'h0034);
  endtask : t_rdw

  // Five back-to-back pushes into a stalled sink: the fifth is refused.
  task automatic t_fill;
    @(posedge mclk);
    stall <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      f_we    <= 1'b1;
      f_wdata <= 16'h0A00 + 16'(i);
    end
    @(posedge mclk);
    f_we <= 1'b0;
    @(negedge mclk);
    chk(f_full, 16'h0001);
    chk(f_ready, 16'h0000);
    chk(f_rdata, 16'h0A00);
    @(posedge mclk);
    stall <= 1'b0;
    wait_empty;
    chk(got_cnt, 16'h0004);
    chk(got_last, 16'h0A03);
  endtask : t_fill

  // Pushes every cycle while the sink reads as soon as a word shows.
  task automatic t_stream;
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      f_we    <= 1'b1;
      f_wdata <= 16'h0B00 + 16'(i);
    end
    @(posedge mclk);
    f_we <= 1'b0;
    wait_empty;
    chk(got_cnt, 16'h000A);
    chk(got_last, 16'h0B05);
  endtask : t_stream

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    t_reset;
    t_mixed;
    t_hold;
    t_rdw;
    t_fill;
    t_stream;
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
